// *** sdl_pkg.sv ***
// Summary of operation
// - Halted-only commands (step, resume) act only while the CPU is halted.
// - Memory and status/control commands run anytime, never stopping the user program.
// - Debug state lives only behind the pin, outside any memory map.
// - Pin level sampled during reset selects debug start or normal run.
// - On-chip pullup holds the pin high when no pod drives it.
// - Serial debug traffic is accepted at any time, no reset needed.
// - Sixteen debug-clock cycles per bit, most significant bit first both ways.
// - After 512 cycles without host falling edge, abort the command harmlessly.
// - Clock-select bit chooses bus clock or alternate source as debug clock.
// - Bit start seen within one cycle of host edge; sample ten cycles later. Here the two-flop sync sees the edge two clocks after it.
// - Target leaves the pin undriven during host-to-target bits.
// - Sending one: brief high speedup pulse seven cycles after bit start.
// - Sending zero: hold pin low 13 cycles, then brief high pulse.
// - A rate-probe request gets a timed response pulse for speed discovery.
// - Probe: wait high, delay 16, drive low 128, one-cycle high pulse, release.
// - Every command opens with an 8-bit code, host to target, MSB first.
// - Delay slot gives the target 16 cycles to carry out the operation.
// - Halt request enters debug mode only if the debug-mode enable bit is set.
package sdl_pkg;

   // ---------------------------------------------
   // Bit timing, in debug-clock cycles
   // ---------------------------------------------
   localparam logic [3:0] SDL_RX_SAMPLE    = 4'hA;   // 10 cycles after start
   localparam logic [3:0] SDL_TX_ONE_PULSE = 4'h7;
   localparam logic [3:0] SDL_TX_ZERO_LOW  = 4'hD;   // 13 cycles low
   localparam logic [3:0] SDL_BIT_LAST     = 4'hF;   // 16 cycles per bit
   localparam logic [9:0] SDL_TIMEOUT      = 10'h0200;
   localparam logic [6:0] SDL_SYNC_DLY_LAST = 7'h0F; // 16 cycles
   localparam logic [6:0] SDL_SYNC_LOW_LAST = 7'h7F; // 128 cycles
   localparam logic [7:0] SDL_SYNC_DETECT  = 8'h80;

   // ---------------------------------------------
   // Field lengths and command codes
   // ---------------------------------------------
   localparam logic [4:0] SDL_CMD_BITS  = 5'h08;
   localparam logic [4:0] SDL_ADDR_BITS = 5'h10;
   localparam logic [4:0] SDL_BYTE_BITS = 5'h08;
   localparam logic [7:0] SDL_CMD_HALT  = 8'h90;
   localparam logic [7:0] SDL_CMD_RSTAT = 8'hE4;
   localparam logic [7:0] SDL_CMD_WCTRL = 8'hC4;
   localparam logic [7:0] SDL_CMD_RBYTE = 8'hE0;
   localparam logic [7:0] SDL_CMD_WBYTE = 8'hC0;
   localparam logic [7:0] SDL_CMD_GO    = 8'h08;
   localparam logic [7:0] SDL_CMD_STEP  = 8'h10;
   localparam logic [7:0] SDL_CMD_TAGGO = 8'h18;

   // ---------------------------------------------
   // Status/control byte layout and reset values
   // ---------------------------------------------
   localparam int unsigned SDL_ST_EN     = 7;
   localparam int unsigned SDL_ST_HALTED = 6;
   localparam int unsigned SDL_ST_CLKSEL = 2;
   localparam logic        SDL_CLKSEL_RST = 1'b0;

   typedef enum logic [2:0] {
      PH_CMD   = 3'b000,
      PH_ADDR  = 3'b001,
      PH_WDATA = 3'b010,
      PH_CTRL  = 3'b011,
      PH_TXD   = 3'b100
   } sdl_phase_t;

   typedef enum logic [1:0] {
      BT_IDLE = 2'b00,
      BT_RX   = 2'b01,
      BT_TX   = 2'b10
   } sdl_bit_t;

   typedef enum logic [2:0] {
      SY_OFF    = 3'b000,
      SY_WAITHI = 3'b001,
      SY_DELAY  = 3'b010,
      SY_LOW    = 3'b011,
      SY_PULSE  = 3'b100
   } sdl_sync_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } sdl_mem_t;

   typedef struct packed {
      logic o;
      logic oe;
   } sdl_pin_t;

   typedef struct packed {
      logic        sync1;
      logic        sync2;
      logic        prev;
      logic        halted;
      logic        en;
      logic        clksel;
      logic        txbit;
      logic        rd_wait;
      logic        we;
      logic        go;
      logic        step;
      sdl_phase_t  phase;
      sdl_bit_t    bit_st;
      sdl_sync_t   sync;
      logic [3:0]  cyc;
      logic [4:0]  nbits;
      logic [9:0]  idle;
      logic [7:0]  lowcnt;
      logic [6:0]  scnt;
      logic [15:0] shreg;
      sdl_mem_t    mem;
      sdl_pin_t    pin;
   } sdl_state_t;

endpackage

// *** sdl_link.sv ***
`timescale 1ns/1ns
module sdl_link
   import sdl_pkg::*;
#(
   parameter logic [7:0] SYNC_DETECT = SDL_SYNC_DETECT
) (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       alt_clk_tick,
   input  wire logic       debug_pin_i,
   output logic            debug_pin_o,
   output logic            debug_pin_oe,
   output logic            debug_pin_pull_en,
   output logic            debug_clock_select,
   output logic            cpu_halt,
   output logic            cpu_go,
   output logic            cpu_step,
   output sdl_mem_t        mem_o,
   input  wire logic       mem_ack,
   input  wire logic [7:0] mem_rdata
);

   // Shorter thresholds would mistake ordinary zero bits for a rate probe
   if (SYNC_DETECT <= 8'h10) begin : g_chk
      $error("SYNC_DETECT must exceed one bit time");
   end

   sdl_state_t state_q;
   sdl_state_t state_d;
   logic       tick;
   logic       fall;
   logic       fall_ok;

   // ---------------------------------------------
   // Debug clock and edge detection
   // ---------------------------------------------
   // clock source select
   assign tick = state_q.clksel ? alt_clk_tick : 1'b1;
   assign fall = state_q.prev & ~state_q.sync2;
   // Own zero drive must not look like a new host edge
   assign fall_ok = fall && (state_q.sync == SY_OFF) &&
                    !(state_q.bit_st == BT_TX && state_q.cyc <= SDL_TX_ZERO_LOW);

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      logic       done;
      logic       abort;
      logic [7:0] byte_in;
      logic [7:0] status;
      done    = 1'b0;
      abort   = 1'b0;
      byte_in = {state_q.shreg[6:0], state_q.sync2};
      // status kept off the memory map
      status                = 8'h00;
      status[SDL_ST_EN]     = state_q.en;
      status[SDL_ST_HALTED] = state_q.halted;
      status[SDL_ST_CLKSEL] = state_q.clksel;

      state_d         = state_q;
      state_d.sync1   = debug_pin_i;
      state_d.sync2   = state_q.sync1;
      state_d.prev    = state_q.sync2;
      state_d.go      = 1'b0;
      state_d.step    = 1'b0;
      state_d.mem.req = 1'b0;

      if (fall) begin
         state_d.idle = '0;
      end else if (tick && state_q.idle != SDL_TIMEOUT) begin
         state_d.idle = state_q.idle + 10'h001;
      end

      if (state_q.sync != SY_OFF || state_q.sync2) begin
         state_d.lowcnt = '0;
      end else if (tick && state_q.lowcnt != 8'hFF) begin
         state_d.lowcnt = state_q.lowcnt + 8'h01;
      end

      case (state_q.bit_st)
         BT_RX: begin
            if (tick) begin
               if (state_q.cyc == SDL_RX_SAMPLE) begin
                  state_d.shreg  = {state_q.shreg[14:0], state_q.sync2};
                  state_d.nbits  = state_q.nbits - 5'h01;
                  state_d.bit_st = BT_IDLE;
                  done           = (state_q.nbits == 5'h01);
               end else begin
                  state_d.cyc = state_q.cyc + 4'h1;
               end
            end
         end
         BT_TX: begin
            if (tick) begin
               if (state_q.cyc == SDL_BIT_LAST) begin
                  state_d.shreg  = {state_q.shreg[14:0], 1'b0};
                  state_d.nbits  = state_q.nbits - 5'h01;
                  state_d.bit_st = BT_IDLE;
                  if (state_q.nbits == 5'h01) begin
                     state_d.phase = PH_CMD;
                     state_d.nbits = SDL_CMD_BITS;
                  end
               end else begin
                  state_d.cyc = state_q.cyc + 4'h1;
               end
            end
         end
         default: begin
         end
      endcase

      if (fall_ok) begin
         state_d.bit_st = (state_q.phase == PH_TXD) ? BT_TX : BT_RX;
         state_d.cyc    = 4'h0;
         state_d.txbit  = state_q.shreg[15];
      end

      if (done) begin
         case (state_q.phase)
            PH_CMD: begin
               state_d.nbits = SDL_CMD_BITS;
               case (byte_in)
                  SDL_CMD_HALT: begin
                     if (state_q.en) begin
                        state_d.halted = 1'b1;
                     end
                  end
                  SDL_CMD_RSTAT: begin
                     state_d.shreg = {status, 8'h00};
                     state_d.phase = PH_TXD;
                     state_d.nbits = SDL_BYTE_BITS;
                  end
                  SDL_CMD_WCTRL: begin
                     state_d.phase = PH_CTRL;
                     state_d.nbits = SDL_BYTE_BITS;
                  end
                  SDL_CMD_RBYTE, SDL_CMD_WBYTE: begin
                     state_d.we    = (byte_in == SDL_CMD_WBYTE);
                     state_d.phase = PH_ADDR;
                     state_d.nbits = SDL_ADDR_BITS;
                  end
                  SDL_CMD_GO, SDL_CMD_TAGGO: begin
                     if (state_q.halted) begin
                        state_d.go     = 1'b1;
                        state_d.halted = 1'b0;
                     end
                  end
                  SDL_CMD_STEP: begin
                     state_d.step = state_q.halted;
                  end
                  default: begin
                  end
               endcase
            end
            PH_ADDR: begin
               state_d.mem.addr = {state_q.shreg[14:0], state_q.sync2};
               if (state_q.we) begin
                  state_d.phase = PH_WDATA;
                  state_d.nbits = SDL_BYTE_BITS;
               end else begin
                  state_d.mem.req = 1'b1;
                  state_d.mem.we  = 1'b0;
                  state_d.rd_wait = 1'b1;
                  state_d.shreg   = 16'h0000;
                  state_d.phase   = PH_TXD;
                  state_d.nbits   = SDL_BYTE_BITS;
               end
            end
            PH_WDATA: begin
               state_d.mem.req   = 1'b1;
               state_d.mem.we    = 1'b1;
               state_d.mem.wdata = byte_in;
               state_d.phase     = PH_CMD;
               state_d.nbits     = SDL_CMD_BITS;
            end
            PH_CTRL: begin
               state_d.en     = byte_in[SDL_ST_EN];
               state_d.clksel = byte_in[SDL_ST_CLKSEL];
               state_d.phase  = PH_CMD;
               state_d.nbits  = SDL_CMD_BITS;
            end
            default: begin
               state_d.phase = PH_CMD;
               state_d.nbits = SDL_CMD_BITS;
            end
         endcase
      end

      // read data from the bus side
      if (state_q.rd_wait && mem_ack) begin
         state_d.shreg   = {mem_rdata, 8'h00};
         state_d.rd_wait = 1'b0;
      end

      if (tick && !fall && state_q.idle == SDL_TIMEOUT - 10'h001) begin
         abort = 1'b1;
      end

      case (state_q.sync)
         SY_OFF: begin
            if (tick && !state_q.sync2 && state_q.lowcnt == SYNC_DETECT - 8'h01) begin
               state_d.sync = SY_WAITHI;
               abort        = 1'b1;
            end
         end
         SY_WAITHI: begin
            if (state_q.sync2) begin
               state_d.sync = SY_DELAY;
               state_d.scnt = 7'h00;
            end
         end
         SY_DELAY: begin
            if (tick) begin
               state_d.scnt = state_q.scnt + 7'h01;
               if (state_q.scnt == SDL_SYNC_DLY_LAST) begin
                  state_d.sync = SY_LOW;
                  state_d.scnt = 7'h00;
               end
            end
         end
         SY_LOW: begin
            if (tick) begin
               state_d.scnt = state_q.scnt + 7'h01;
               if (state_q.scnt == SDL_SYNC_LOW_LAST) begin
                  state_d.sync = SY_PULSE;
               end
            end
         end
         SY_PULSE: begin
            if (tick) begin
               state_d.sync = SY_OFF;
            end
         end
         default: begin
            state_d.sync = SY_OFF;
         end
      endcase

      // back to command wait, mode untouched
      if (abort) begin
         state_d.phase   = PH_CMD;
         state_d.bit_st  = BT_IDLE;
         state_d.nbits   = SDL_CMD_BITS;
         state_d.rd_wait = 1'b0;
         state_d.mem.req = 1'b0;
      end

      // Pin drive follows the next state so it lines up with it
      // no drive during host bits
      state_d.pin = '0;
      if (state_d.sync == SY_LOW) begin
         state_d.pin.oe = 1'b1;
      end else if (state_d.sync == SY_PULSE) begin
         state_d.pin = '{o: 1'b1, oe: 1'b1};
      end else if (state_d.bit_st == BT_TX) begin
         if (state_d.txbit) begin
            state_d.pin.oe = (state_d.cyc == SDL_TX_ONE_PULSE);
            state_d.pin.o  = 1'b1;
         end else begin
            state_d.pin.oe = (state_d.cyc <= SDL_TX_ZERO_LOW);
            state_d.pin.o  = (state_d.cyc == SDL_TX_ZERO_LOW);
         end
      end

      if (sys_rst) begin
         state_d        = '0;
         state_d.nbits  = SDL_CMD_BITS;
         state_d.clksel = SDL_CLKSEL_RST;
         state_d.halted = ~debug_pin_i;
         state_d.en     = ~debug_pin_i;
      end
   end

   always_ff @(posedge clk) begin
      state_q <= state_d;
   end

   assign debug_pin_o        = state_q.pin.o;
   assign debug_pin_oe       = state_q.pin.oe;
   assign debug_pin_pull_en  = 1'b1;
   assign debug_clock_select = state_q.clksel;
   assign cpu_halt           = state_q.halted;
   assign cpu_go             = state_q.go;
   assign cpu_step           = state_q.step;
   assign mem_o              = state_q.mem;

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_rx_undriven: assert property (state_q.bit_st == BT_RX |-> !state_q.pin.oe)
      else $error("pin driven during host bit");
   a_zero_hold: assert property ((state_q.bit_st == BT_TX && !state_q.txbit && state_q.cyc < SDL_TX_ZERO_LOW)
      |-> state_q.pin.oe && !state_q.pin.o)
      else $error("zero bit not held low");
   a_one_pulse: assert property ((state_q.bit_st == BT_TX && state_q.txbit)
      |-> state_q.pin.oe == (state_q.cyc == SDL_TX_ONE_PULSE))
      else $error("one bit pulse misplaced");
   a_edge_start: assert property ((fall_ok && state_q.phase == PH_CMD) |=> state_q.bit_st == BT_RX && state_q.cyc == 4'h0)
      else $error("host edge did not start bit");
   a_sample_end: assert property ((state_q.bit_st == BT_RX && state_q.cyc == SDL_RX_SAMPLE && tick && !fall)
      |=> state_q.bit_st == BT_IDLE)
      else $error("bit not sampled at ten");
   a_timeout_abort: assert property ((tick && !fall && state_q.idle == SDL_TIMEOUT - 10'h001)
      |=> state_q.phase == PH_CMD && state_q.bit_st == BT_IDLE && state_q.nbits == SDL_CMD_BITS)
      else $error("timeout did not abort");
   a_halt_enabled: assert property ($rose(state_q.halted) |-> $past(state_q.en))
      else $error("halt entered while disabled");
   a_go_halted: assert property (state_q.go |-> !state_q.halted && $past(state_q.halted))
      else $error("resume while running");
   a_sync_low: assert property ((state_q.sync == SY_DELAY && tick && state_q.scnt == SDL_SYNC_DLY_LAST)
      |=> state_q.sync == SY_LOW && state_q.pin.oe && !state_q.pin.o)
      else $error("probe response not driven low");
   a_strap_sample: assert property ($fell(sys_rst) |-> state_q.halted == !$past(debug_pin_i))
      else $error("strap not sampled");

   c_resume: cover property (state_q.go);
   c_probe: cover property (state_q.sync == SY_PULSE);
   c_mem_write: cover property (state_q.mem.req && state_q.mem.we);
   c_mem_read: cover property (state_q.rd_wait && mem_ack);

endmodule

// *** sdl_pod_model.sv ***
`timescale 1ns/1ns
module sdl_pod_model (
   input  wire logic clk,
   input  wire logic pin,
   output logic      pod_o,
   output logic      pod_oe,
   output logic      sending
);
   // Clocks per debug cycle; raised when the target runs from the slow tick
   int dc = 1;

   initial begin
      pod_o   = 1'h1;
      pod_oe  = 1'h0;
      sending = 1'h0;
   end

   task automatic hold(input int n, input logic oe, input logic v);
      pod_oe <= oe;
      pod_o  <= v;
      repeat (n) @(posedge clk);
   endtask

   task automatic idle(input int n);
      sending <= 1'h0;
      hold(n * dc, 1'h0, 1'h1);
   endtask

   task automatic send_bit(input logic b);
      sending <= 1'h1;
      if (b) begin
         hold(4 * dc, 1'h1, 1'h0);
         hold(14 * dc, 1'h1, 1'h1);
         hold(2 * dc, 1'h0, 1'h1);
      end else begin
         hold(14 * dc, 1'h1, 1'h0);
         hold(1, 1'h1, 1'h1);
         hold(6 * dc - 1, 1'h0, 1'h1);
      end
   endtask

   task automatic send8(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) send_bit(v[i]);
   endtask

   task automatic send16(input logic [15:0] v);
      send8(v[15:8]);
      send8(v[7:0]);
   endtask

   task automatic recv8(output logic [7:0] v);
      v = 8'h00;
      sending <= 1'h0;
      for (int i = 0; i < 8; i++) begin
         hold(2 * dc, 1'h1, 1'h0);
         hold(8 * dc, 1'h0, 1'h1);
         v = {v[6:0], pin};
         hold(10 * dc, 1'h0, 1'h1);
      end
   endtask

   task automatic probe(input int low_len, output int reply);
      int waited;
      waited = 0;
      reply  = 0;
      sending <= 1'h0;
      hold(low_len * dc, 1'h1, 1'h0);
      hold(1, 1'h1, 1'h1);
      pod_oe <= 1'h0;
      while (pin !== 1'h0 && waited < 400) begin
         @(posedge clk);
         waited++;
      end
      while (pin === 1'h0 && reply < 600) begin
         @(posedge clk);
         reply++;
      end
   endtask
endmodule

// *** test_single_wire_debug_link.sv ***
`timescale 1ns/1ns
module test_single_wire_debug_link;
   import sdl_pkg::*;
   logic        clk, sys_rst, alt_clk_tick, mem_ack;
   logic [7:0]  mem_rdata, rd;
   logic [7:0]  mem_arr [0:255];
   logic        pin_o, pin_oe, pull_en, clk_sel, halt, go, step, pod_o, pod_oe, sending;
   wire logic   pin;
   sdl_mem_t    mem_o, last_req;
   logic [15:0] req_count, go_count, step_count;
   int          fail_count, total_checks, cycles, reply;

   // Pseudo-open-drain wire: both low wins, nobody driving falls to the pullup
   assign pin = pin_oe ? (pod_oe ? (pin_o & pod_o) : pin_o) : (pod_oe ? pod_o : pull_en);

   sdl_link #(
      .SYNC_DETECT(8'h28)
   ) sdl_link_i (
      .clk               (clk),
      .sys_rst           (sys_rst),
      .alt_clk_tick      (alt_clk_tick),
      .debug_pin_i       (pin),
      .debug_pin_o       (pin_o),
      .debug_pin_oe      (pin_oe),
      .debug_pin_pull_en (pull_en),
      .debug_clock_select(clk_sel),
      .cpu_halt          (halt),
      .cpu_go            (go),
      .cpu_step          (step),
      .mem_o             (mem_o),
      .mem_ack           (mem_ack),
      .mem_rdata         (mem_rdata)
   );

   sdl_pod_model sdl_pod_model_i (
      .clk    (clk),
      .pin    (pin),
      .pod_o  (pod_o),
      .pod_oe (pod_oe),
      .sending(sending)
   );

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   // ---------------------------------------------
   // Memory side, pulse counters, watchdog
   // ---------------------------------------------
   always @(posedge clk) begin
      alt_clk_tick <= sys_rst ? 1'h0 : ~alt_clk_tick;
      mem_ack      <= mem_o.req;
      if (mem_o.req === 1'h1) begin
         req_count <= req_count + 16'h0001;
         last_req  <= mem_o;
         mem_rdata <= mem_arr[mem_o.addr[7:0]];
         if (mem_o.we) mem_arr[mem_o.addr[7:0]] <= mem_o.wdata;
      end
      go_count   <= go_count + {15'h0000, go === 1'h1};
      step_count <= step_count + {15'h0000, step === 1'h1};
      cycles     <= cycles + 1;
      if (sending && pin_oe !== 1'h0) begin
         fail_count++;
         $display("CHECK FAILED target drive during host bit expected 0 seen %b", pin_oe);
      end
      if (cycles == 40000) begin
         fail_count++;
         conclude();
      end
   end

   task automatic conclude();
      if (fail_count == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic do_reset(input logic strap_low);
      sdl_pod_model_i.hold(1, strap_low, 1'h0);
      sys_rst <= 1'h1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'h0;
      @(posedge clk);
      sdl_pod_model_i.idle(4);
   endtask

   task automatic status(input logic [7:0] exp);
      sdl_pod_model_i.send8(SDL_CMD_RSTAT);
      sdl_pod_model_i.recv8(rd);
      sdl_pod_model_i.idle(4);
      check("status byte", exp, rd);
   endtask

   // Delay slot after commands that act inside the target
   task automatic cmd(input logic [7:0] c);
      sdl_pod_model_i.send8(c);
      sdl_pod_model_i.idle(16);
   endtask

   task automatic wctrl(input logic [7:0] v);
      sdl_pod_model_i.send8(SDL_CMD_WCTRL);
      sdl_pod_model_i.send8(v);
      sdl_pod_model_i.idle(4);
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_strap();
      do_reset(1'h1);
      check("halt after low strap", 1'h1, halt);
      do_reset(1'h0);
      check("halt after high strap", 1'h0, halt);
      check("pullup enable", 1'h1, pull_en);
      check("clock select reset", 1'h0, clk_sel);
   endtask

   task automatic t_modes();
      status(8'h00);
      cmd(SDL_CMD_HALT);
      check("halt while disabled", 1'h0, halt);
      cmd(SDL_CMD_GO);
      cmd(SDL_CMD_STEP);
      cmd(SDL_CMD_TAGGO);
      check("go while running", 16'h0000, go_count);
      check("step while running", 16'h0000, step_count);
      wctrl(8'h80);
      cmd(SDL_CMD_HALT);
      check("halt while enabled", 1'h1, halt);
      status(8'hC0);
      cmd(SDL_CMD_STEP);
      check("step pulses", 16'h0001, step_count);
      check("halt after step", 1'h1, halt);
      cmd(SDL_CMD_TAGGO);
      check("go pulses", 16'h0001, go_count);
      cmd(SDL_CMD_HALT);
      cmd(SDL_CMD_GO);
      check("go after halt", 16'h0002, go_count);
      check("run after go", 1'h0, halt);
   endtask

   task automatic t_mem();
      do_reset(1'h0);
      sdl_pod_model_i.send8(SDL_CMD_WBYTE);
      sdl_pod_model_i.send16(16'h1234);
      sdl_pod_model_i.send8(8'hA5);
      sdl_pod_model_i.idle(16);
      check("write requests", 16'h0001, req_count);
      check("write address", 16'h1234, last_req.addr);
      check("write data", 8'hA5, last_req.wdata);
      check("write direction", 1'h1, last_req.we);
      sdl_pod_model_i.send8(SDL_CMD_RBYTE);
      sdl_pod_model_i.send16(16'h1234);
      sdl_pod_model_i.idle(16);
      sdl_pod_model_i.recv8(rd);
      sdl_pod_model_i.idle(4);
      check("read data", 8'hA5, rd);
      check("read direction", 1'h0, last_req.we);
      check("user program kept", 1'h0, halt);
   endtask

   task automatic t_abort();
      sdl_pod_model_i.send8(SDL_CMD_WBYTE);
      sdl_pod_model_i.send16(16'h1234);
      for (int i = 0; i < 4; i++) sdl_pod_model_i.send_bit(1'h1);
      sdl_pod_model_i.idle(600);
      check("aborted write", 16'h0002, req_count);
      check("mode after abort", 1'h0, halt);
      status(8'h00);
   endtask

   task automatic t_probe(input int low_len, input logic [15:0] exp);
      sdl_pod_model_i.probe(low_len, reply);
      check("probe low length", exp, reply[15:0]);
      check("probe speedup", 2'h3, {pin_oe, pin_o});
      sdl_pod_model_i.idle(4);
   endtask

   task automatic t_altclk();
      wctrl(8'h84);
      check("clock select set", 1'h1, clk_sel);
      sdl_pod_model_i.dc = 2;
      status(8'h84);
      t_probe(48, 16'h0100);
      status(8'h84);
   endtask

   initial begin
      sys_rst      = 1'h1;
      alt_clk_tick = 1'h0;
      mem_ack      = 1'h0;
      mem_rdata    = 8'h00;
      req_count    = 16'h0000;
      go_count     = 16'h0000;
      step_count   = 16'h0000;
      fail_count   = 0;
      total_checks = 0;
      cycles       = 0;
      for (int i = 0; i < 256; i++) mem_arr[i] = 8'h00;
      @(posedge clk);
      t_strap();
      t_modes();
      t_mem();
      t_abort();
      t_probe(48, 16'h0080);
      status(8'h00);
      t_altclk();
      conclude();
   end
endmodule
